// ===== drp_pkg.sv
// drp_pkg: register offsets, field positions, reset values and encodings
// of the single dma channel. assumes a 32-bit register port.
`default_nettype none
package drp_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTL  = 8'h00;
  localparam logic [7:0] OFS_ISRC = 8'h04;
  localparam logic [7:0] OFS_IDES = 8'h08;
  localparam logic [7:0] OFS_ICNT = 8'h0c;
  localparam logic [7:0] OFS_CSRC = 8'h10;
  localparam logic [7:0] OFS_CDES = 8'h14;
  localparam logic [7:0] OFS_CCNT = 8'h18;
  // control register fields
  localparam int CTL_STATE_LSB = 4;
  localparam int CTL_GATE_LSB  = 2;
  localparam int CTL_CMD_LSB   = 0;
  localparam logic [1:0] CMD_NONE   = 2'h0;
  localparam logic [1:0] CMD_START  = 2'h1;
  localparam logic [1:0] CMD_PAUSE  = 2'h2;
  localparam logic [1:0] CMD_CANCEL = 2'h3;
  localparam logic [1:0] GATE_OPEN  = 2'h0;
  localparam logic [1:0] ST_READY    = 2'h0;
  localparam logic [1:0] ST_COUNTING = 2'h1;
  localparam logic [1:0] ST_TERMINAL = 2'h2;
  // address register fields
  localparam int ADR_SIZE_LSB = 30;
  localparam int ADR_DIR_LSB  = 28;
  localparam int ADR_BITS     = 28;
  localparam logic [1:0] DIR_INC   = 2'h1;
  localparam logic [1:0] DIR_DEC   = 2'h2;
  localparam logic [1:0] DIR_FIXED = 2'h3;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // initial count register fields
  localparam int CNT_PROT_LSB = 30;
  localparam int CNT_MODE_LSB = 28;
  localparam int CNT_SEL_LSB  = 25;
  localparam int CNT_AR_BIT   = 24;
  localparam int CNT_EN_BIT   = 23;
  localparam int CNT_BITS     = 20;
  localparam logic [1:0] PROT_WHOLE  = 2'h0;
  localparam logic [1:0] PROT_DEMAND = 2'h1;
  localparam logic [1:0] MODE_UNIT   = 2'h0;
  localparam logic [1:0] MODE_BLOCK  = 2'h1;
  localparam logic [1:0] MODE_OTF    = 2'h2;
  // block burst, hardware sources, reset value, fsm states
  localparam int           BLK_BEATS = 4;
  localparam logic [4:0]   BLK_BYTES = 5'h10;
  localparam int           HW_SRCS   = 5;
  localparam logic [31:0]  REG_RST   = 32'h0000_0000;
  typedef enum logic [2:0] {S_IDLE, S_REQ, S_RD, S_WR, S_OTF, S_END, S_REL} drp_state_e;
endpackage
`default_nettype wire

// ===== drp_sync.sv
// drp_sync: two-flop synchroniser for pin levels.
// assumes the pins are asynchronous to ref_clk.
`default_nettype none
module drp_sync #(
  parameter int         W   = 1,
  parameter logic [0:0] IDL = 1'b1
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] sync
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;
  always_comb
  begin
    next_meta = pin;
    next_sync = meta;
  end
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= {W{IDL}};
      sync <= {W{IDL}};
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
    end
  end
endmodule
`default_nettype wire

// ===== drp_channel.sv
// drp_channel: one dma channel with request protocols, transfer modes,
// request source selection and paired initial/current registers.
// assumes a single-beat memory port acknowledged by mem_done and an
// arbiter that grants via bus_grant on the same clock.
//
// Overview of operation
// - whole mode: one request runs full count
// - whole mode: ack held until count done
// - whole mode: release bus after each unit (block mode: after each block)
// - whole mode: resume after other master, no request
// - demand mode: transfer while request held
// - demand mode: bus locked until operation ends
// - unit mode: one read then one write
// - block mode: four word reads, four writes
// - block mode: stop below sixteen bytes remaining
// - on-the-fly: single memory access per unit
// - on-the-fly: own data drivers stay off
// - command 01 starts configured channel
// - software start runs until less than one unit (block mode: 16 bytes) remains
// - external request honoured only if gated open
// - bridge channel: selectable hardware request source
// - auto reload copies initial when less than one unit (block mode: 16 bytes) remains
// - reload never restarts by itself
// - initial set plus live current set
// - initial writes apply at next reload
// - enable rising edge copies initial set
// - cancel command copies initial set
// - command self-clears; pause; start whole only
// - state field: ready, counting, terminal
// - gate 00 enables external request
`default_nettype none
module drp_channel
  import drp_pkg::*;
#(
  parameter int CNT_W  = drp_pkg::CNT_BITS,
  parameter bit BRIDGE = 1'b0
) (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 ext_dma_request_n,
  output logic                      ext_dma_ack_n,
  input  wire logic [HW_SRCS-1:0]   hw_req,
  output logic                      bus_req,
  output logic                      bus_lock,
  input  wire logic                 bus_grant,
  output logic [ADR_BITS-1:0]       mem_addr,
  output logic [1:0]                mem_size,
  output logic                      mem_rd,
  output logic                      mem_wr,
  output logic [31:0]               mem_wdata,
  output logic                      data_oe,
  input  wire logic [31:0]          mem_rdata,
  input  wire logic                 mem_done
);
  import drp_pkg::*;

  // refuse count widths that cannot hold a block or overlap the enable bit
  if (CNT_W < 5 || CNT_W > CNT_EN_BIT)
  begin
    $error("CNT_W out of range");
  end

  logic              req_n_s;
  logic              ext_q;
  logic [1:0]        gate;
  logic [1:0]        st;
  logic              paused;
  logic [31:0]       isrc;
  logic [31:0]       ides;
  logic [31:0]       icnt;
  logic [31:0]       csrc;
  logic [31:0]       cdes;
  logic [CNT_W-1:0]  ccnt;
  logic [1:0]        beat;
  logic [31:0]       buf_q [BLK_BEATS];
  drp_state_e        fsm;
  logic [1:0]        next_gate;
  logic [1:0]        next_st;
  logic              next_paused;
  logic [31:0]       next_isrc;
  logic [31:0]       next_ides;
  logic [31:0]       next_icnt;
  logic [31:0]       next_csrc;
  logic [31:0]       next_cdes;
  logic [CNT_W-1:0]  next_ccnt;
  logic [1:0]        next_beat;
  logic [31:0]       next_buf [BLK_BEATS];
  drp_state_e        next_fsm;
  logic [31:0]       next_rdata;

  drp_sync #(.W(1), .IDL(1'b1)) u_req_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (ext_dma_request_n),
    .sync    (req_n_s)
  );

  // decoded configuration
  logic [1:0]        prot;
  logic [1:0]        mode;
  logic [2:0]        sel;
  logic              ar;
  logic              en;
  logic              whole;
  logic              demand;
  logic [1:0]        size;
  logic [CNT_W-1:0]  unit_bytes;
  logic [CNT_W-1:0]  svc_bytes;
  logic              fin;
  logic              ext_lvl;
  logic              hw_lvl;
  logic              ctl_wr;
  logic [1:0]        cmd;
  logic              sw_start;
  logic              do_cancel;
  logic              trig;
  logic              mem_is_src;
  logic              last_beat;

  assign prot       = icnt[CNT_PROT_LSB +: 2];
  assign mode       = icnt[CNT_MODE_LSB +: 2];
  assign sel        = icnt[CNT_SEL_LSB +: 3];
  assign ar         = icnt[CNT_AR_BIT];
  assign en         = icnt[CNT_EN_BIT];
  assign whole      = (prot == PROT_WHOLE);
  assign demand     = (prot == PROT_DEMAND);
  assign size       = (mode == MODE_BLOCK) ? SIZE_WORD : csrc[ADR_SIZE_LSB +: 2];
  assign unit_bytes = CNT_W'(1) << size;
  assign svc_bytes  = (mode == MODE_BLOCK) ? CNT_W'(BLK_BYTES) : unit_bytes;
  assign fin        = (ccnt < svc_bytes);
  assign ext_lvl    = !req_n_s && (gate == GATE_OPEN);
  assign hw_lvl     = BRIDGE && sel != 3'h0 && sel <= 3'(HW_SRCS)
                      && hw_req[sel - 3'h1];
  assign ctl_wr     = reg_wr && reg_addr == OFS_CTL;
  assign cmd        = reg_wdata[CTL_CMD_LSB +: 2];
  assign sw_start   = ctl_wr && cmd == CMD_START && whole;
  assign do_cancel  = ctl_wr && cmd == CMD_CANCEL;
  // whole mode starts on a request edge, demand mode on the level
  assign trig       = en && (sw_start || hw_lvl
                      || (demand ? ext_lvl : ext_lvl && !ext_q));
  // on-the-fly: memory is the source unless the source is the fixed device
  assign mem_is_src = csrc[ADR_DIR_LSB +: 2] != DIR_FIXED;
  assign last_beat  = (mode != MODE_BLOCK) || beat == 2'(BLK_BEATS - 1);

  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] sz);
    logic [ADR_BITS-1:0] inc;
    inc = ADR_BITS'(1) << sz;
    step = a;
    if (a[ADR_DIR_LSB +: 2] == DIR_INC)
      step[ADR_BITS-1:0] = a[ADR_BITS-1:0] + inc;
    else if (a[ADR_DIR_LSB +: 2] == DIR_DEC)
      step[ADR_BITS-1:0] = a[ADR_BITS-1:0] - inc;
  endfunction

  always_comb
  begin
    next_gate   = gate;
    next_st     = st;
    next_paused = paused;
    next_isrc   = isrc;
    next_ides   = ides;
    next_icnt   = icnt;
    next_csrc   = csrc;
    next_cdes   = cdes;
    next_ccnt   = ccnt;
    next_beat   = beat;
    next_buf    = buf_q;
    next_fsm    = fsm;
    // initial set always takes writes; current set sees them only on a copy
    if (reg_wr && reg_addr == OFS_ISRC)
      next_isrc = reg_wdata;
    if (reg_wr && reg_addr == OFS_IDES)
      next_ides = reg_wdata;
    if (reg_wr && reg_addr == OFS_ICNT)
      next_icnt = reg_wdata;
    if (ctl_wr)
      next_gate = reg_wdata[CTL_GATE_LSB +: 2];
    case (fsm)
      S_IDLE:
      begin
        if (trig && !fin)
        begin
          next_paused = 1'b0;
          next_fsm    = S_REQ;
        end
        else if (trig)
          next_st = ST_TERMINAL;
      end
      S_REQ:
      begin
        if (bus_grant)
          next_fsm = (mode == MODE_OTF) ? S_OTF : S_RD;
      end
      S_RD:
      begin
        if (mem_done)
        begin
          next_buf[beat] = mem_rdata;
          next_csrc      = step(csrc, size);
          next_beat      = last_beat ? 2'h0 : beat + 2'h1;
          if (last_beat)
            next_fsm = S_WR;
        end
      end
      S_WR:
      begin
        if (mem_done)
        begin
          next_cdes = step(cdes, size);
          next_beat = last_beat ? 2'h0 : beat + 2'h1;
          if (last_beat)
          begin
            next_ccnt = ccnt - svc_bytes;
            next_st   = ST_COUNTING;
            next_fsm  = S_END;
          end
        end
      end
      S_OTF:
      begin
        if (mem_done)
        begin
          if (mem_is_src)
            next_csrc = step(csrc, size);
          else
            next_cdes = step(cdes, size);
          next_ccnt = ccnt - unit_bytes;
          next_st   = ST_COUNTING;
          next_fsm  = S_END;
        end
      end
      S_END:
      begin
        if (fin)
        begin
          next_st  = ST_TERMINAL;
          next_fsm = S_IDLE;
          if (ar)
          begin
            next_csrc = isrc;
            next_cdes = ides;
            next_ccnt = icnt[CNT_W-1:0];
            next_st   = ST_READY;
          end
        end
        else if (paused)
          next_fsm = S_IDLE;
        else if (demand)
          // request gone: stop here and keep the current set
          next_fsm = ext_lvl ? ((mode == MODE_OTF) ? S_OTF : S_RD)
                             : S_IDLE;
        else
          next_fsm = S_REL;
      end
      S_REL:
        next_fsm = S_REQ;
      default:
        next_fsm = S_IDLE;
    endcase
    // a pause wins over a start in the same cycle
    if (ctl_wr && cmd == CMD_PAUSE)
      next_paused = 1'b1;
    // enable rising edge or cancel reloads the current set at once
    if ((reg_wr && reg_addr == OFS_ICNT && reg_wdata[CNT_EN_BIT] && !en) || do_cancel)
    begin
      next_csrc = (reg_wr && reg_addr == OFS_ISRC) ? reg_wdata : isrc;
      next_cdes = ides;
      next_ccnt = (reg_wr && reg_addr == OFS_ICNT) ? reg_wdata[CNT_W-1:0]
                                                   : icnt[CNT_W-1:0];
      next_st   = ST_READY;
      next_beat = 2'h0;
      if (do_cancel)
      begin
        next_fsm    = S_IDLE;
        next_paused = 1'b0;
      end
    end
  end

  // register reads; the command field always reads back as zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTL:  next_rdata = 32'({st, gate, CMD_NONE});
        OFS_ISRC: next_rdata = isrc;
        OFS_IDES: next_rdata = ides;
        OFS_ICNT: next_rdata = icnt;
        OFS_CSRC: next_rdata = csrc;
        OFS_CDES: next_rdata = cdes;
        OFS_CCNT: next_rdata = 32'(ccnt);
        default:  next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_q     <= 1'b0;
      gate      <= GATE_OPEN;
      st        <= ST_READY;
      paused    <= 1'b0;
      isrc      <= REG_RST;
      ides      <= REG_RST;
      icnt      <= REG_RST;
      csrc      <= REG_RST;
      cdes      <= REG_RST;
      ccnt      <= '0;
      beat      <= 2'h0;
      buf_q     <= '{default: REG_RST};
      fsm       <= S_IDLE;
      reg_rdata <= REG_RST;
    end
    else
    begin
      ext_q     <= ext_lvl;
      gate      <= next_gate;
      st        <= next_st;
      paused    <= next_paused;
      isrc      <= next_isrc;
      ides      <= next_ides;
      icnt      <= next_icnt;
      csrc      <= next_csrc;
      cdes      <= next_cdes;
      ccnt      <= next_ccnt;
      beat      <= next_beat;
      buf_q     <= next_buf;
      fsm       <= next_fsm;
      reg_rdata <= next_rdata;
    end
  end

  // bus and pin outputs
  assign bus_req       = fsm != S_IDLE && fsm != S_REL;
  assign bus_lock      = bus_req && demand;
  assign ext_dma_ack_n = (fsm == S_IDLE);
  assign mem_rd        = fsm == S_RD || (fsm == S_OTF && mem_is_src);
  assign mem_wr        = fsm == S_WR || (fsm == S_OTF && !mem_is_src);
  assign mem_addr      = (fsm == S_WR || (fsm == S_OTF && !mem_is_src))
                         ? cdes[ADR_BITS-1:0] : csrc[ADR_BITS-1:0];
  assign mem_size      = size;
  assign mem_wdata     = buf_q[beat];
  assign data_oe       = (fsm == S_WR);

  // checks
  property p_otf_no_drive;
    @(posedge ref_clk) disable iff (!resetn)
    (fsm == S_OTF) |-> !data_oe && (mem_rd ^ mem_wr);
  endproperty
  a_otf_no_drive: assert property (p_otf_no_drive)
    else $error("on-the-fly drives data bus");
  property p_whole_release;
    @(posedge ref_clk) disable iff (!resetn)
    (fsm == S_END && whole && !fin && !paused && !do_cancel) |=> !bus_req ##1 bus_req;
  endproperty
  a_whole_release: assert property (p_whole_release)
    else $error("whole mode did not release bus between units");
  property p_demand_lock;
    @(posedge ref_clk) disable iff (!resetn)
    demand && (fsm == S_RD || fsm == S_WR) |-> bus_lock && !ext_dma_ack_n;
  endproperty
  a_demand_lock: assert property (p_demand_lock)
    else $error("demand transfer without bus lock");
  property p_cancel_copy;
    @(posedge ref_clk) disable iff (!resetn)
    do_cancel && !(reg_wr && reg_addr != OFS_CTL) |=> fsm == S_IDLE
      && ccnt == $past(icnt[CNT_W-1:0]) && cdes == $past(ides);
  endproperty
  a_cancel_copy: assert property (p_cancel_copy)
    else $error("cancel did not reload current set");
  property p_enable_copy;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(en) |-> ccnt == icnt[CNT_W-1:0] && st == ST_READY;
  endproperty
  a_enable_copy: assert property (p_enable_copy)
    else $error("enable edge did not reload current set");
  property p_terminal;
    @(posedge ref_clk) disable iff (!resetn)
    (fsm == S_END && fin && !ar && !do_cancel) |=> st == ST_TERMINAL && fsm == S_IDLE
      && ext_dma_ack_n;
  endproperty
  a_terminal: assert property (p_terminal)
    else $error("terminal count not reported");
  property p_block_burst;
    @(posedge ref_clk) disable iff (!resetn)
    (mode == MODE_BLOCK && fsm == S_REQ && bus_grant && !do_cancel) |=> fsm == S_RD
      && beat == 2'h0;
  endproperty
  a_block_burst: assert property (p_block_burst)
    else $error("block burst did not start at first beat");
  property p_reload_idle;
    @(posedge ref_clk) disable iff (!resetn)
    (fsm == S_END && fin && ar && !do_cancel) |=> fsm == S_IDLE && st == ST_READY
      && csrc == $past(isrc);
  endproperty
  a_reload_idle: assert property (p_reload_idle)
    else $error("auto reload wrong or restarted");
  property p_unit_count;
    @(posedge ref_clk) disable iff (!resetn)
    (fsm == S_WR && mem_done && mode == MODE_UNIT && !do_cancel)
      |=> ccnt == $past(ccnt) - $past(unit_bytes);
  endproperty
  a_unit_count: assert property (p_unit_count)
    else $error("unit write did not decrement count");
  property p_sw_start;
    @(posedge ref_clk) disable iff (!resetn)
    (fsm == S_IDLE && sw_start && en && !fin) |=> fsm == S_REQ ##0 bus_req;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software start ignored");
  c_block: cover property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_BLOCK && fsm == S_WR && mem_done && beat == 2'h3);
  c_demand_stop: cover property (@(posedge ref_clk) disable iff (!resetn)
    demand && fsm == S_END && !fin ##1 fsm == S_IDLE);
  c_reload: cover property (@(posedge ref_clk) disable iff (!resetn)
    fsm == S_END && fin && ar);
endmodule
`default_nettype wire

// ===== drp_placeholder_none.sv
`default_nettype none
`default_nettype wire

// ===== drp_far_model.sv
// drp_far_model: request pin, bus arbiter and memory beside one channel.
// assumes same-clock grant and one mem_done pulse per memory beat.
`default_nettype none
module drp_far_model (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        want,
  input  wire logic        steal,
  input  wire logic [3:0]  mem_wait,
  input  wire logic        bus_req,
  input  wire logic        bus_lock,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [27:0] mem_addr,
  output logic             ext_dma_request_n,
  output logic             bus_grant,
  output logic             mem_done,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0]  wait_cnt;
  logic [31:0] noise;
  assign ext_dma_request_n = ~want;
  // other master wins between units unless locked
  assign bus_grant = bus_req & (bus_lock | ~steal);
  // stale read data is never left on the bus
  assign mem_rdata = mem_done ? {4'h0, mem_addr} : noise;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_cnt <= 4'h0;
      mem_done <= 1'b0;
      noise    <= 32'h0;
    end
    else
    begin
      noise    <= noise + 32'h9e37_79b9;
      mem_done <= 1'b0;
      // one memory access per beat; a dropped strobe aborts it
      if ((mem_rd || mem_wr) && !mem_done)
      begin
        if (wait_cnt >= mem_wait)
        begin
          mem_done <= 1'b1;
          wait_cnt <= 4'h0;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
      else
        wait_cnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ===== dma_request_protocol_reload_tb_top.sv
// dma_request_protocol_reload_tb_top: register-level tests of one channel.
// assumes drp_channel with BRIDGE=0 and drp_far_model on its far side.
`default_nettype none
module dma_request_protocol_reload_tb_top import drp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, resetn, reg_wr, reg_rd, want, steal;
  logic        ext_dma_request_n, ext_dma_ack_n, bus_req, bus_lock, bus_grant;
  logic        mem_rd, mem_wr, data_oe, mem_done, ack_q, req_q;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_rdata, mem_wdata, log_q, v, rdv [4];
  logic [1:0]  mem_size;
  logic [27:0] mem_addr;
  logic [3:0]  mem_wait;
  int          bad_count, checks_done, beats, ack_rise, rel, oe_cnt, nolock, b, ri, wi, wdbad;

  drp_channel dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_dma_request_n(ext_dma_request_n), .ext_dma_ack_n(ext_dma_ack_n),
    .hw_req(5'h00), .bus_req(bus_req), .bus_lock(bus_lock), .bus_grant(bus_grant),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .data_oe(data_oe), .mem_rdata(mem_rdata), .mem_done(mem_done));
  drp_far_model far (.ref_clk(ref_clk), .resetn(resetn), .want(want), .steal(steal),
    .mem_wait(mem_wait), .bus_req(bus_req), .bus_lock(bus_lock), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .ext_dma_request_n(ext_dma_request_n),
    .bus_grant(bus_grant), .mem_done(mem_done), .mem_rdata(mem_rdata));

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  // beat log: 0 read, 1 write, newest in bit 0
  always @(posedge ref_clk)
  begin
    if (mem_done && (mem_rd || mem_wr))
    begin
      beats++;
      log_q = {log_q[30:0], mem_wr};
    end
    if (!ack_q && ext_dma_ack_n) ack_rise++;
    if (req_q && !bus_req) rel++;
    if (data_oe) oe_cnt++;
    if (bus_req && !bus_lock) nolock++;
    // written data must be what was read, beat for beat
    if (mem_done && mem_rd)
    begin
      rdv[ri % 4] = mem_rdata;
      ri++;
    end
    if (mem_done && data_oe)
    begin
      if (mem_wdata !== rdv[wi % 4]) wdbad++;
      wi++;
    end
    if ((mem_rd || mem_wr) && mem_size !== SIZE_WORD) wdbad++;
    ack_q = ext_dma_ack_n;
    req_q = bus_req;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic chk_cnt(input string what, input logic [19:0] exp);
    rd(OFS_CCNT, v);
    chk(what, {12'h0, exp}, {12'h0, v[19:0]});
  endtask

  task automatic chk_adr(input string what, input logic [7:0] a, input logic [27:0] exp);
    rd(a, v);
    chk(what, {4'h0, exp}, {4'h0, v[27:0]});
  endtask

  function automatic logic [31:0] adr(input logic [1:0] dir, input logic [27:0] a);
    return {SIZE_WORD, dir, a};
  endfunction

  function automatic logic [31:0] cnt(input logic [1:0] prot, input logic [1:0] mode,
                                      input logic ar, input logic [19:0] n);
    return {prot, mode, 3'h0, ar, 1'b1, 3'h0, n};
  endfunction

  // enable low then high so the current set is reloaded
  task automatic cfg(input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
    wr(OFS_ISRC, s);
    wr(OFS_IDES, d);
    wr(OFS_ICNT, c & 32'hff7f_ffff);
    wr(OFS_ICNT, c);
    {beats, ack_rise, rel, oe_cnt, nolock} = '0;
    log_q = 32'h0;
  endtask

  task automatic wait_term();
    v = 32'h0;
    for (int i = 0; i < 300 && v[5:4] !== ST_TERMINAL; i++) rd(OFS_CTL, v);
  endtask

  task automatic wait_beats(input int k);
    for (int i = 0; i < 600 && beats < k; i++) @(posedge ref_clk);
  endtask

  initial
  begin
    {resetn, reg_wr, reg_rd, want, steal, reg_addr, reg_wdata} = '0;
    {bad_count, checks_done, beats, ack_rise, rel, oe_cnt, nolock, b, ri, wi, wdbad} = '0;
    {ack_q, req_q, log_q, mem_wait} = {1'b1, 1'b0, 32'h0, 4'h1};
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_CTL, v);
    chk("ctl reset", REG_RST, v);
    wr(OFS_CCNT, 32'h55);
    chk_cnt("current count read-only", 20'h0);
    rd(8'h40, v);
    chk("unmapped read", 32'h0, v);
    // whole service, unit mode, software start, another master steals
    cfg(adr(DIR_INC, 28'h100), adr(DIR_INC, 28'h180), cnt(PROT_WHOLE, MODE_UNIT, 1'b0, 20'h8));
    chk_cnt("enable copies count", 20'h8);
    rd(OFS_CTL, v);
    chk("ctl ready", 32'h0, v);
    wr(OFS_CTL, {30'h0, CMD_START});
    steal <= 1'b1;
    repeat (30) @(posedge ref_clk);
    steal <= 1'b0;
    wait_term();
    chk("unit beats", 32'h4, beats);
    chk("unit order", 32'h5, {28'h0, log_q[3:0]});
    chk("ack held", 32'h1, ack_rise);
    chk("bus released", 32'h1, {31'h0, rel >= 2});
    rd(OFS_CTL, v);
    chk("ctl terminal", {26'h0, ST_TERMINAL, GATE_OPEN, CMD_NONE}, v);
    chk_cnt("count at zero", 20'h0);
    chk_adr("live source", OFS_CSRC, 28'h108);
    chk_adr("live dest", OFS_CDES, 28'h188);
    // block mode with reload; new initial count written mid-run
    cfg(adr(DIR_INC, 28'h200), adr(DIR_INC, 28'h300),
        cnt(PROT_WHOLE, MODE_BLOCK, 1'b1, 20'h24));
    wr(OFS_CTL, {30'h0, CMD_START});
    wr(OFS_ICNT, cnt(PROT_WHOLE, MODE_BLOCK, 1'b1, 20'h20));
    wait_beats(16);
    repeat (60) @(posedge ref_clk);
    chk("block beats", 32'h10, beats);
    chk("block order", 32'h0f0f, {16'h0, log_q[15:0]});
    chk_cnt("reloaded count", 20'h20);
    chk_adr("reloaded source", OFS_CSRC, 28'h200);
    // demand mode, gate closed then open, request dropped mid-run
    cfg(adr(DIR_INC, 28'h600), adr(DIR_INC, 28'h680),
        cnt(PROT_DEMAND, MODE_UNIT, 1'b0, 20'h10));
    wr(OFS_CTL, 32'h4);
    steal <= 1'b1;
    want  <= 1'b1;
    repeat (30) @(posedge ref_clk);
    chk("gate closed", 32'h0, beats);
    wr(OFS_CTL, 32'h0);
    wait_beats(4);
    want <= 1'b0;
    repeat (40) @(posedge ref_clk);
    b = beats;
    chk("demand stops", 32'h1, {31'h0, b < 8 && b[0] == 1'b0});
    chk_cnt("demand keeps count", 20'h10 - 20'(2 * b));
    rd(OFS_CTL, v);
    chk("ctl counting", {26'h0, ST_COUNTING, GATE_OPEN, CMD_NONE}, v);
    want <= 1'b1;
    wait_term();
    chk("demand beats", 32'h8, beats);
    chk("bus locked", 32'h0, nolock);
    want  <= 1'b0;
    steal <= 1'b0;
    // on-the-fly from a fixed device source, started by one request pulse
    cfg(adr(DIR_FIXED, 28'h0), adr(DIR_INC, 28'h700), cnt(PROT_WHOLE, MODE_OTF, 1'b0, 20'h8));
    want <= 1'b1;
    repeat (6) @(posedge ref_clk);
    want <= 1'b0;
    wait_term();
    chk("otf beats", 32'h2, beats);
    chk("otf writes only", 32'h3, {30'h0, log_q[1:0]});
    chk("otf drivers off", 32'h0, oe_cnt);
    chk("otf ack held", 32'h1, ack_rise);
    chk("write data", 32'h0, wdbad);
    // pause, resume, then cancel during a slow run
    mem_wait <= 4'hf;
    cfg(adr(DIR_INC, 28'h800), adr(DIR_INC, 28'h880), cnt(PROT_WHOLE, MODE_UNIT, 1'b0, 20'h10));
    wr(OFS_CTL, {30'h0, CMD_START});
    wait_beats(1);
    wr(OFS_CTL, {30'h0, CMD_PAUSE});
    repeat (60) @(posedge ref_clk);
    chk("pause stops", 32'h2, beats);
    chk_cnt("pause keeps count", 20'hc);
    wr(OFS_CTL, {30'h0, CMD_START});
    wait_beats(3);
    wr(OFS_CTL, {30'h0, CMD_CANCEL});
    chk_cnt("cancel reloads count", 20'h10);
    chk_adr("cancel reloads source", OFS_CSRC, 28'h800);
    chk("cancel idles", 32'h1, {31'h0, ext_dma_ack_n});
    b = beats;
    repeat (80) @(posedge ref_clk);
    chk("no beats after cancel", b, beats);
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
